/* File: hdl/sspst_status.sv */
// module: serial port status register with AXI4-Lite access and link event capture
// How it works
// - sample phase set samples at end, outside I2C mode
// - in I2C sample phase disables slew control
// - edge select, inverted by clock polarity
// - data/address flag marks last byte kind
// - stop flag shows stop seen last
// - start flag shows start seen last
// - port disable clears start and stop
// - direction bit held from address match
// - slave read/write shows transmit in progress
// - address update flag requests address rewrite
// - completed reception sets buffer full
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
module sspst_status
  import sspst_pkg::*;
(
  // system
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // link
  input  wire logic        i_link_clk,
  input  wire logic        i_link_rst,
  input  wire logic        i_start_seen,
  input  wire logic        i_stop_seen,
  input  wire logic        i_nack_seen,
  input  wire logic        i_addr_match,
  input  wire logic        i_addr_dir,
  input  wire logic        i_byte_done,
  input  wire logic        i_byte_is_data,
  input  wire logic        i_rx_done,
  input  wire logic        i_tx_active,
  input  wire logic        i_addr_update,
  input  wire logic        i_buf_read,
  // axi write
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // axi read
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // port controls
  output logic             o_sample_end,
  output logic             o_slew_disable,
  output logic             o_tx_rising,
  output logic             o_port_enable
);
  logic [7:0]  status;
  logic [7:0]  next_status;
  logic [3:0]  control;
  logic [3:0]  next_control;
  logic        aw_held;
  logic        next_aw_held;
  logic [7:0]  aw_addr;
  logic [7:0]  next_aw_addr;
  logic        w_held;
  logic        next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic        w_lane;
  logic        next_w_lane;
  sspst_wstate_t wstate;
  sspst_wstate_t next_wstate;
  logic [1:0]  bresp;
  logic [1:0]  next_bresp;
  logic        rvalid;
  logic        next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;
  logic        p_start;
  logic        p_stop;
  logic        p_nack;
  logic        p_match;
  logic        p_data;
  logic        p_addr;
  logic        p_rx;
  logic        p_read;
  logic [1:0]  lvl_meta;
  logic [1:0]  lvl_sync;
  logic        dir_meta;
  logic        dir_sync;
  logic        do_write;

  // ======================================================================
  // crossings
  sspst_event_sync u_start (.i_link_clk(i_link_clk), .i_link_rst(i_link_rst),
    .i_event(i_start_seen), .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_pulse(p_start));
  sspst_event_sync u_stop (.i_link_clk(i_link_clk), .i_link_rst(i_link_rst),
    .i_event(i_stop_seen), .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_pulse(p_stop));
  sspst_event_sync u_nack (.i_link_clk(i_link_clk), .i_link_rst(i_link_rst),
    .i_event(i_nack_seen), .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_pulse(p_nack));
  sspst_event_sync u_match (.i_link_clk(i_link_clk), .i_link_rst(i_link_rst),
    .i_event(i_addr_match), .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_pulse(p_match));
  sspst_event_sync u_data (.i_link_clk(i_link_clk), .i_link_rst(i_link_rst),
    .i_event(i_byte_done & i_byte_is_data), .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .o_pulse(p_data));
  sspst_event_sync u_addr (.i_link_clk(i_link_clk), .i_link_rst(i_link_rst),
    .i_event(i_byte_done & ~i_byte_is_data), .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .o_pulse(p_addr));
  sspst_event_sync u_rx (.i_link_clk(i_link_clk), .i_link_rst(i_link_rst),
    .i_event(i_rx_done), .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_pulse(p_rx));
  sspst_event_sync u_read (.i_link_clk(i_link_clk), .i_link_rst(i_link_rst),
    .i_event(i_buf_read), .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_pulse(p_read));

  // direction is held stable by the link for the match pulse crossing time
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lvl_meta <= 2'h0;
      lvl_sync <= 2'h0;
      dir_meta <= 1'b0;
      dir_sync <= 1'b0;
    end else begin
      lvl_meta <= {i_tx_active, i_addr_update};
      lvl_sync <= lvl_meta;
      dir_meta <= i_addr_dir;
      dir_sync <= dir_meta;
    end
  end

  // ======================================================================
  // status register
  assign do_write = (wstate == SSPST_IDLE) && aw_held && w_held;
  always_comb begin
    next_status = status;
    next_control = control;
    if (do_write && w_lane && aw_addr == STATUS_ADDR) begin
      next_status[BIT_SAMPLE] = w_data[BIT_SAMPLE];
      next_status[BIT_EDGE]   = w_data[BIT_EDGE];
    end
    if (do_write && w_lane && aw_addr == CONTROL_ADDR) begin
      next_control = w_data[3:0];
    end
    if (p_data) begin
      next_status[BIT_DATA_ADDR] = 1'b1;
    end else if (p_addr) begin
      next_status[BIT_DATA_ADDR] = 1'b0;
    end
    if (p_stop) begin
      next_status[BIT_STOP]  = 1'b1;
      next_status[BIT_START] = 1'b0;
    end else if (p_start) begin
      next_status[BIT_START] = 1'b1;
      next_status[BIT_STOP]  = 1'b0;
    end
    if (!next_control[BIT_PORT_EN]) begin
      next_status[BIT_STOP]  = 1'b0;
      next_status[BIT_START] = 1'b0;
    end
    if (control[BIT_SLAVE]) begin
      next_status[BIT_READ_WR] = lvl_sync[1];
    end else if (p_match) begin
      next_status[BIT_READ_WR] = dir_sync;
    end else if (p_start || p_stop || p_nack) begin
      next_status[BIT_READ_WR] = 1'b0;
    end
    next_status[BIT_ADDR_UPD] = lvl_sync[0];
    if (p_rx) begin
      next_status[BIT_BUF_FULL] = 1'b1;
    end else if (p_read) begin
      next_status[BIT_BUF_FULL] = 1'b0;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status  <= STATUS_RESET;
      control <= CONTROL_RESET;
    end else begin
      status  <= next_status;
      control <= next_control;
    end
  end

  // ======================================================================
  // port controls
  assign o_sample_end   = status[BIT_SAMPLE] & ~control[BIT_I2C_MODE];
  assign o_slew_disable = status[BIT_SAMPLE] & control[BIT_I2C_MODE];
  assign o_tx_rising    = status[BIT_EDGE] ^ control[BIT_POLARITY];
  assign o_port_enable  = control[BIT_PORT_EN];

  // ======================================================================
  // axi write channel
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_lane  = w_lane;
    next_wstate  = wstate;
    next_bresp   = bresp;
    if (i_awvalid && o_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_held = 1'b1;
      next_w_data = i_wdata;
      next_w_lane = i_wstrb[0];
    end
    unique case (wstate)
      SSPST_IDLE: begin
        if (do_write) begin
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_wstate  = SSPST_RESP;
          next_bresp   = (aw_addr == STATUS_ADDR || aw_addr == CONTROL_ADDR) ?
                         RESP_OKAY : RESP_SLVERR;
        end
      end
      SSPST_RESP: begin
        if (i_bready) begin
          next_wstate = SSPST_IDLE;
        end
      end
      default: begin
        next_wstate = SSPST_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_lane  <= 1'b0;
      wstate  <= SSPST_IDLE;
      bresp   <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_lane  <= next_w_lane;
      wstate  <= next_wstate;
      bresp   <= next_bresp;
    end
  end
  assign o_awready = ~aw_held;
  assign o_wready  = ~w_held;
  assign o_bvalid  = (wstate == SSPST_RESP);
  assign o_bresp   = bresp;

  // ======================================================================
  // axi read channel
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (!rvalid && i_arvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (i_araddr == STATUS_ADDR) begin
        next_rdata = {24'h00_0000, status};
      end else if (i_araddr == CONTROL_ADDR) begin
        next_rdata = {28'h000_0000, control};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end
  assign o_arready = ~rvalid;
  assign o_rvalid  = rvalid;
  assign o_rdata   = rdata;
  assign o_rresp   = rresp;

  // ======================================================================
  // checks
  sequence s_disabled;
    !control[BIT_PORT_EN];
  endsequence
  a_disable_clears_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_disabled |-> !status[BIT_START] && !status[BIT_STOP])
    else $error("start or stop flag set while port disabled");
  a_start_stop_exclusive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !(status[BIT_START] && status[BIT_STOP]))
    else $error("start and stop flags both set");
  a_start_sets_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    p_start && !p_stop && control[BIT_PORT_EN] && next_control[BIT_PORT_EN]
    |=> status[BIT_START])
    else $error("start event did not set start flag");
  a_stop_sets_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    p_stop && next_control[BIT_PORT_EN] |=> status[BIT_STOP])
    else $error("stop event did not set stop flag");
  a_rx_sets_full: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    p_rx |=> status[BIT_BUF_FULL])
    else $error("reception did not set buffer full");
  a_data_flag_kind: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    p_addr && !p_data |=> !status[BIT_DATA_ADDR])
    else $error("address byte left data flag set");
  a_edge_select_map: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    control[BIT_POLARITY] ? (o_tx_rising == !status[BIT_EDGE]) : (o_tx_rising == status[BIT_EDGE]))
    else $error("edge select mismatch");
  a_flags_ignore_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    do_write && !p_rx && !p_read |=> $stable(status[BIT_BUF_FULL]))
    else $error("buffer full changed by write");
  a_write_answers: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    do_write |=> o_bvalid)
    else $error("write response missing");
endmodule

/* File: hdl/sspst_pkg.sv */
// package: register map, field positions and reset values of the serial port status block
package sspst_pkg;
  // ======================================================================
  // register map
  localparam int unsigned STATUS_INDEX  = 32'h13;
  // byte address is four times the register index
  localparam logic [7:0]  STATUS_ADDR   = 8'(STATUS_INDEX * 4);
  localparam logic [7:0]  CONTROL_ADDR  = 8'h50;
  // ======================================================================
  // status fields
  localparam int unsigned BIT_SAMPLE    = 7;
  localparam int unsigned BIT_EDGE      = 6;
  localparam int unsigned BIT_DATA_ADDR = 5;
  localparam int unsigned BIT_STOP      = 4;
  localparam int unsigned BIT_START     = 3;
  localparam int unsigned BIT_READ_WR   = 2;
  localparam int unsigned BIT_ADDR_UPD  = 1;
  localparam int unsigned BIT_BUF_FULL  = 0;
  // ======================================================================
  // control fields
  localparam int unsigned BIT_PORT_EN   = 0;
  localparam int unsigned BIT_POLARITY  = 1;
  localparam int unsigned BIT_I2C_MODE  = 2;
  localparam int unsigned BIT_SLAVE     = 3;
  // ======================================================================
  // reset values and bus answers
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [3:0]  CONTROL_RESET = 4'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {SSPST_IDLE, SSPST_RESP} sspst_wstate_t;
endpackage

/* File: hdl/sspst_event_sync.sv */
// module: toggle crossing of one link-domain event into the system clock
`timescale 1ns/10ps
module sspst_event_sync (
  // link side
  input  wire logic i_link_clk,
  input  wire logic i_link_rst,
  input  wire logic i_event,
  // system side
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  output logic      o_pulse
);
  logic tog;
  logic next_tog;
  logic meta;
  logic sync;
  logic last;

  // ======================================================================
  // link domain toggle
  always_comb begin
    next_tog = tog ^ i_event;
  end
  always_ff @(posedge i_link_clk or posedge i_link_rst) begin
    if (i_link_rst) begin
      tog <= 1'b0;
    end else begin
      tog <= next_tog;
    end
  end

  // ======================================================================
  // system domain capture
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= tog;
      sync <= meta;
      last <= sync;
    end
  end
  assign o_pulse = sync ^ last;
endmodule

/* File: test/sspst_bus_partner.sv */
// model of the external bus partner: link clock, bus events and link levels
`timescale 1ns/10ps
module sspst_bus_partner (
  // link clock, stands still between frames
  output logic       o_link_clk,
  // one-link-cycle events: start, stop, nack, match, byte, rx done, buffer read
  output logic [6:0] o_pulse,
  // link levels
  output logic       o_tx_active,
  output logic       o_addr_update,
  output logic       o_addr_dir,
  output logic       o_byte_is_data
);
  // ======================================================================
  // idle state
  initial begin
    o_link_clk     = 1'b0;
    o_pulse        = 7'h00;
    o_tx_active    = 1'b0;
    o_addr_update  = 1'b0;
    o_addr_dir     = 1'b0;
    o_byte_is_data = 1'b0;
  end
  // ======================================================================
  // levels change well before the next event frame
  task automatic set_levels(input logic tx, input logic upd, input logic dir, input logic dat);
    o_tx_active    = tx;
    o_addr_update  = upd;
    o_addr_dir     = dir;
    o_byte_is_data = dat;
  endtask
  // ======================================================================
  // one frame of five link cycles, the event pulse is sampled at the second edge
  task automatic send_event(input int unsigned kind);
    #17.3;
    o_link_clk = 1'b1;
    #1 o_pulse = 7'h01 << kind;
    #23 o_link_clk = 1'b0;
    repeat (4) begin
      #24 o_link_clk = 1'b1;
      #1 o_pulse = 7'h00;
      #23 o_link_clk = 1'b0;
    end
  endtask
endmodule

/* File: test/sspst_status_tb.sv */
// testbench: register access, port controls and link events of the status block
`timescale 1ns/10ps
module sspst_status_tb
  import sspst_pkg::*;
;
  localparam int K_START = 0, K_STOP = 1, K_NACK = 2, K_MATCH = 3;
  localparam int K_BYTE = 4, K_RX = 5, K_READ = 6;
  localparam int LIMIT = 20000;
  logic        i_clk, i_sys_rst, i_link_clk, i_link_rst;
  logic [6:0]  pulse;
  logic        tx_active, addr_update, addr_dir, byte_is_data;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata;
  logic [3:0]  i_wstrb;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic        o_sample_end, o_slew_disable, o_tx_rising, o_port_enable;
  int          err_count, n_tests, cycles, i;
  // ======================================================================
  // design and partner
  sspst_status u_sspst_status (
    .i_clk, .i_sys_rst, .i_link_clk, .i_link_rst,
    .i_start_seen(pulse[0]), .i_stop_seen(pulse[1]), .i_nack_seen(pulse[2]),
    .i_addr_match(pulse[3]), .i_addr_dir(addr_dir), .i_byte_done(pulse[4]),
    .i_byte_is_data(byte_is_data), .i_rx_done(pulse[5]), .i_tx_active(tx_active),
    .i_addr_update(addr_update), .i_buf_read(pulse[6]),
    .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .o_sample_end, .o_slew_disable, .o_tx_rising,
    .o_port_enable
  );
  sspst_bus_partner u_sspst_bus_partner (
    .o_link_clk(i_link_clk), .o_pulse(pulse), .o_tx_active(tx_active),
    .o_addr_update(addr_update), .o_addr_dir(addr_dir), .o_byte_is_data(byte_is_data)
  );
  // ======================================================================
  // clock and timeout
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end
  // ======================================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ======================================================================
  // bus tasks
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    logic pa;
    logic pw;
    @(posedge i_clk);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_wstrb   <= s;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    do begin
      @(posedge i_clk);
      if (pa && o_awready === 1'b1) begin
        i_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && o_wready === 1'b1) begin
        i_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    check({30'h0, o_bresp}, {30'h0, er});
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input logic [1:0] er);
    logic pr;
    @(posedge i_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    pr = 1'b1;
    do begin
      @(posedge i_clk);
      if (pr && o_arready === 1'b1) begin
        i_arvalid <= 1'b0;
        pr = 1'b0;
      end
    end while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    check(o_rdata & m, e);
    check({30'h0, o_rresp}, {30'h0, er});
  endtask
  task automatic status_is(input logic [7:0] m, input logic [7:0] e);
    axi_read(STATUS_ADDR, {24'h0, m}, {24'h0, e}, RESP_OKAY);
  endtask
  // ======================================================================
  // tests
  initial begin
    {i_sys_rst, i_link_rst} = 2'h3;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_wstrb, i_wdata} = 52'h0;
    {err_count, n_tests, cycles} = 96'h0;
    repeat (6) @(posedge i_clk);
    i_sys_rst  <= 1'b0;
    i_link_rst <= 1'b0;
    status_is(8'hFF, 8'h00);
    axi_read(CONTROL_ADDR, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    axi_read(8'h40, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    $display("test reset values done");
    axi_write(STATUS_ADDR, 32'hFF, 4'hF, RESP_OKAY);
    status_is(8'hFF, 8'hC0);
    axi_write(STATUS_ADDR, 32'h00, 4'hE, RESP_OKAY);
    status_is(8'hFF, 8'hC0);
    axi_write(8'h44, 32'h1, 4'hF, RESP_SLVERR);
    $display("test write access done");
    for (i = 0; i < 8; i++) begin
      // slave bit stays clear while sample phase may be set
      axi_write(CONTROL_ADDR, {29'h0, i[0], i[1], 1'b1}, 4'hF, RESP_OKAY);
      axi_write(STATUS_ADDR, {24'h0, i[2], i[0] ^ i[2], 6'h00}, 4'h1, RESP_OKAY);
      @(posedge i_clk);
      check({31'h0, o_sample_end}, {31'h0, i[2] & ~i[0]});
      check({31'h0, o_slew_disable}, {31'h0, i[2] & i[0]});
      check({31'h0, o_tx_rising}, {31'h0, i[0] ^ i[1] ^ i[2]});
      check({31'h0, o_port_enable}, 32'h1);
    end
    $display("test port controls done");
    axi_write(CONTROL_ADDR, 32'h5, 4'hF, RESP_OKAY);
    u_sspst_bus_partner.send_event(K_START);
    status_is(8'h18, 8'h08);
    u_sspst_bus_partner.send_event(K_STOP);
    status_is(8'h18, 8'h10);
    u_sspst_bus_partner.send_event(K_START);
    axi_write(CONTROL_ADDR, 32'h4, 4'hF, RESP_OKAY);
    status_is(8'h18, 8'h00);
    axi_write(CONTROL_ADDR, 32'h5, 4'hF, RESP_OKAY);
    $display("test start and stop done");
    u_sspst_bus_partner.set_levels(1'b0, 1'b0, 1'b1, 1'b0);
    u_sspst_bus_partner.send_event(K_MATCH);
    status_is(8'h04, 8'h04);
    u_sspst_bus_partner.send_event(K_NACK);
    status_is(8'h04, 8'h00);
    u_sspst_bus_partner.send_event(K_MATCH);
    u_sspst_bus_partner.send_event(K_STOP);
    status_is(8'h04, 8'h00);
    $display("test direction done");
    axi_write(CONTROL_ADDR, 32'hD, 4'hF, RESP_OKAY);
    u_sspst_bus_partner.set_levels(1'b1, 1'b1, 1'b0, 1'b1);
    u_sspst_bus_partner.send_event(K_BYTE);
    status_is(8'h26, 8'h26);
    u_sspst_bus_partner.set_levels(1'b0, 1'b0, 1'b0, 1'b0);
    u_sspst_bus_partner.send_event(K_BYTE);
    status_is(8'h26, 8'h00);
    u_sspst_bus_partner.send_event(K_RX);
    status_is(8'h01, 8'h01);
    u_sspst_bus_partner.send_event(K_READ);
    status_is(8'h01, 8'h00);
    $display("test slave flags done");
    report_and_stop();
  end
endmodule
